// ===== core/mcr_backoff_lfsr.sv
// backoff random number generator for the transmit function
`timescale 1ns/1ps
`default_nettype none
`include "mcr_cfg.svh"

module mcr_backoff_lfsr (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        hold_seed,
  // value
  output var  logic [15:0] value_o
);

  logic [15:0] value_ff;
  logic [15:0] nxt_value;

  // galois step; a zero state cannot occur since the seed is nonzero
  always_comb begin
    if (hold_seed) begin
      nxt_value = `MCR_LFSR_SEED;
    end else if (value_ff[0]) begin
      nxt_value = (value_ff >> 1) ^ `MCR_LFSR_TAPS;
    end else begin
      nxt_value = value_ff >> 1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_ff <= `MCR_LFSR_SEED;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value_o = value_ff;

endmodule : mcr_backoff_lfsr
`default_nettype wire

// ===== core/mcr_cfg.svh
// offsets, field positions, reset values and codes for the mac configuration block
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

// byte addresses of the register and its alias locations
`define MCR_OFF_CFG     8'h00
`define MCR_OFF_SET     8'h04
`define MCR_OFF_CLR     8'h08
`define MCR_OFF_INV     8'h0c

// field positions
`define MCR_B_WIDE      15
`define MCR_B_BACKOFF   14
`define MCR_B_RXCSL     11
`define MCR_B_RXPATH    10
`define MCR_B_TXCSL     9
`define MCR_B_TXPATH    8
`define MCR_B_LOOP      4
`define MCR_B_PSEND     3
`define MCR_B_POBEY     2
`define MCR_B_ALLFR     1
`define MCR_B_RXON      0

// reset value and implemented bits
`define MCR_CFG_RST     16'h800d
`define MCR_CFG_IMPL    16'hcf1f

// backoff random generator
`define MCR_LFSR_SEED   16'hace1
`define MCR_LFSR_TAPS   16'hb400

// bus answers
`define MCR_RESP_OKAY   2'h0
`define MCR_RESP_SLVERR 2'h2

`endif

// ===== core/mcr_pkg.sv
// types shared by the mac configuration block
package mcr_pkg;

  typedef enum logic [1:0] {
    MCR_WR_COLLECT = 2'h1,
    MCR_WR_RESP    = 2'h2
  } mcr_wr_state_e;

  typedef enum logic [1:0] {
    MCR_ALIAS_PLAIN = 2'h0,
    MCR_ALIAS_SET   = 2'h1,
    MCR_ALIAS_CLR   = 2'h2,
    MCR_ALIAS_INV   = 2'h3
  } mcr_alias_e;

  typedef struct packed {
    logic mac_wide_reset_hold;
    logic backoff_random_reset;
    logic rx_control_sublayer_reset;
    logic rx_path_reset;
    logic tx_control_sublayer_reset;
    logic tx_path_reset;
    logic loopback;
    logic pause_send_allow;
    logic pause_obey;
    logic accept_every_frame;
    logic receive_on;
  } mcr_ctrl_s;

endpackage : mcr_pkg

// ===== core/mcr_top.sv
// mac configuration and sub-layer reset register with an axi4-lite slave
// Functional notes
// - bit 15 holds whole mac in reset
// - bit 14 resets transmit backoff generator
// - bit 11 holds receive control sub-layer
// - bit 10 holds receive function logic
// - bit 9 holds transmit control sub-layer
// - bit 8 holds transmit function logic
// - bit 4 loops transmit into receive
// - bit 3 allows sending pause frames
// - bit 2 obeys received pause frames
// - bit 1 accepts control frames too
// - bit 0 enables frame reception
// - byte-wide writes are ignored
// - set, clear, invert aliases take halfword/word
// - reset value has bits 15,3,2,0 set
// - unimplemented bits read as zero
`timescale 1ns/1ps
`default_nettype none
`include "mcr_cfg.svh"

module mcr_top (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // axi4-lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output var  logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output var  logic             s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]       s_axi_bresp,
  output var  logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output var  logic             s_axi_arready,
  output var  logic [31:0]      s_axi_rdata,
  output var  logic [1:0]       s_axi_rresp,
  output var  logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // mac controls
  output var  mcr_pkg::mcr_ctrl_s ctrl_o,
  output var  logic [15:0]      backoff_random_value
);

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[7:4] == 4'h0) && (a[1:0] == 2'h0);
  endfunction : addr_mapped

  // halfword or word lanes only
  function automatic logic width_ok(input logic [3:0] s);
    width_ok = (s == 4'hf) || (s == 4'h3) || (s == 4'hc);
  endfunction : width_ok

  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] d,
                                        input logic [3:0] s, input logic [7:0] a);
    logic [15:0] m;
    logic [15:0] r;
    m = d[15:0] & {{8{s[1]}}, {8{s[0]}}};
    r = cur;
    unique case (mcr_pkg::mcr_alias_e'(a[3:2]))
      mcr_pkg::MCR_ALIAS_PLAIN: r = (cur & ~{{8{s[1]}}, {8{s[0]}}}) | m;
      mcr_pkg::MCR_ALIAS_SET:   r = cur | m;
      mcr_pkg::MCR_ALIAS_CLR:   r = cur & ~m;
      mcr_pkg::MCR_ALIAS_INV:   r = cur ^ m;
    endcase
    merge = r & `MCR_CFG_IMPL;
  endfunction : merge

  // the whole-mac hold overrides every sub-layer hold
  function automatic mcr_pkg::mcr_ctrl_s ctrl_of(input logic [15:0] c);
    mcr_pkg::mcr_ctrl_s k;
    k.mac_wide_reset_hold       = c[`MCR_B_WIDE];
    k.backoff_random_reset      = c[`MCR_B_BACKOFF] | c[`MCR_B_WIDE];
    k.rx_control_sublayer_reset = c[`MCR_B_RXCSL] | c[`MCR_B_WIDE];
    k.rx_path_reset             = c[`MCR_B_RXPATH] | c[`MCR_B_WIDE];
    k.tx_control_sublayer_reset = c[`MCR_B_TXCSL] | c[`MCR_B_WIDE];
    k.tx_path_reset             = c[`MCR_B_TXPATH] | c[`MCR_B_WIDE];
    k.loopback                  = c[`MCR_B_LOOP];
    k.pause_send_allow          = c[`MCR_B_PSEND];
    k.pause_obey                = c[`MCR_B_POBEY];
    k.accept_every_frame        = c[`MCR_B_ALLFR];
    k.receive_on                = c[`MCR_B_RXON];
    ctrl_of = k;
  endfunction : ctrl_of

  mcr_pkg::mcr_wr_state_e wr_state_ff;
  mcr_pkg::mcr_wr_state_e nxt_wr_state;
  logic                   aw_got_ff;
  logic                   nxt_aw_got;
  logic                   w_got_ff;
  logic                   nxt_w_got;
  logic [7:0]             waddr_ff;
  logic [7:0]             nxt_waddr;
  logic [31:0]            wdata_ff;
  logic [31:0]            nxt_wdata;
  logic [3:0]             wstrb_ff;
  logic [3:0]             nxt_wstrb;
  logic                   awready_ff;
  logic                   nxt_awready;
  logic                   wready_ff;
  logic                   nxt_wready;
  logic                   bvalid_ff;
  logic                   nxt_bvalid;
  logic [1:0]             bresp_ff;
  logic [1:0]             nxt_bresp;
  logic                   arready_ff;
  logic                   nxt_arready;
  logic                   rvalid_ff;
  logic                   nxt_rvalid;
  logic [31:0]            rdata_ff;
  logic [31:0]            nxt_rdata;
  logic [1:0]             rresp_ff;
  logic [1:0]             nxt_rresp;
  logic [15:0]            cfg_ff;
  logic [15:0]            nxt_cfg;
  mcr_pkg::mcr_ctrl_s     ctrl_ff;
  logic                   wr_commit;
  logic                   wr_apply;

  assign wr_commit = (wr_state_ff == mcr_pkg::MCR_WR_COLLECT) && aw_got_ff && w_got_ff;
  assign wr_apply  = wr_commit && addr_mapped(waddr_ff) && width_ok(wstrb_ff);

  // write channel
  always_comb begin
    nxt_wr_state = wr_state_ff;
    nxt_aw_got   = aw_got_ff;
    nxt_w_got    = w_got_ff;
    nxt_waddr    = waddr_ff;
    nxt_wdata    = wdata_ff;
    nxt_wstrb    = wstrb_ff;
    nxt_bvalid   = bvalid_ff;
    nxt_bresp    = bresp_ff;
    unique case (wr_state_ff)
      mcr_pkg::MCR_WR_COLLECT: begin
        if (s_axi_awvalid && awready_ff) begin
          nxt_aw_got = 1'b1;
          nxt_waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
          nxt_w_got = 1'b1;
          nxt_wdata = s_axi_wdata;
          nxt_wstrb = s_axi_wstrb;
        end
        if (wr_commit) begin
          nxt_wr_state = mcr_pkg::MCR_WR_RESP;
          nxt_bvalid   = 1'b1;
          // ignored byte writes still answer okay; only a bad address errors
          nxt_bresp    = addr_mapped(waddr_ff) ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
        end
      end
      mcr_pkg::MCR_WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wr_state = mcr_pkg::MCR_WR_COLLECT;
          nxt_bvalid   = 1'b0;
          nxt_aw_got   = 1'b0;
          nxt_w_got    = 1'b0;
        end
      end
      default: begin
        nxt_wr_state = mcr_pkg::MCR_WR_COLLECT;
        nxt_bvalid   = 1'b0;
        nxt_aw_got   = 1'b0;
        nxt_w_got    = 1'b0;
      end
    endcase
    nxt_awready = (nxt_wr_state == mcr_pkg::MCR_WR_COLLECT) && !nxt_aw_got;
    nxt_wready  = (nxt_wr_state == mcr_pkg::MCR_WR_COLLECT) && !nxt_w_got;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= mcr_pkg::MCR_WR_COLLECT;
      aw_got_ff   <= 1'b0;
      w_got_ff    <= 1'b0;
      waddr_ff    <= 8'h00;
      wdata_ff    <= 32'h0000_0000;
      wstrb_ff    <= 4'h0;
      awready_ff  <= 1'b0;
      wready_ff   <= 1'b0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= `MCR_RESP_OKAY;
    end else begin
      wr_state_ff <= nxt_wr_state;
      aw_got_ff   <= nxt_aw_got;
      w_got_ff    <= nxt_w_got;
      waddr_ff    <= nxt_waddr;
      wdata_ff    <= nxt_wdata;
      wstrb_ff    <= nxt_wstrb;
      awready_ff  <= nxt_awready;
      wready_ff   <= nxt_wready;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
    end
  end

  // read channel; every alias reads back the register itself
  always_comb begin
    // ready again whenever no read answer is pending, including after reset
    nxt_arready = arready_ff | ~rvalid_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid  = 1'b0;
      nxt_arready = 1'b1;
    end else if (s_axi_arvalid && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid  = 1'b1;
      nxt_rdata   = addr_mapped(s_axi_araddr) ? {16'h0000, cfg_ff & `MCR_CFG_IMPL} : 32'h0000_0000;
      nxt_rresp   = addr_mapped(s_axi_araddr) ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `MCR_RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // configuration register
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_apply) begin
      nxt_cfg = merge(cfg_ff, wdata_ff, wstrb_ff, waddr_ff);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff  <= `MCR_CFG_RST;
      ctrl_ff <= ctrl_of(`MCR_CFG_RST);
    end else begin
      cfg_ff  <= nxt_cfg;
      ctrl_ff <= ctrl_of(nxt_cfg);
    end
  end

  mcr_backoff_lfsr u_lfsr (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .hold_seed (ctrl_ff.backoff_random_reset),
    .value_o   (backoff_random_value)
  );

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign ctrl_o        = ctrl_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wide_hold;
    cfg_ff[`MCR_B_WIDE] |-> ctrl_ff.mac_wide_reset_hold && ctrl_ff.rx_path_reset && ctrl_ff.tx_path_reset
      && ctrl_ff.rx_control_sublayer_reset && ctrl_ff.tx_control_sublayer_reset;
  endproperty
  a_wide_hold: assert property (p_wide_hold) else $error("mac not fully held in reset");

  property p_backoff_seed;
    ctrl_ff.backoff_random_reset |=> backoff_random_value == `MCR_LFSR_SEED;
  endproperty
  a_backoff_seed: assert property (p_backoff_seed) else $error("backoff generator not reseeded");

  property p_rx_csl;
    ctrl_ff.rx_control_sublayer_reset == (cfg_ff[`MCR_B_RXCSL] | cfg_ff[`MCR_B_WIDE]);
  endproperty
  a_rx_csl: assert property (p_rx_csl) else $error("rx control sub-layer reset mismatch");

  property p_rx_path;
    ctrl_ff.rx_path_reset == (cfg_ff[`MCR_B_RXPATH] | cfg_ff[`MCR_B_WIDE]);
  endproperty
  a_rx_path: assert property (p_rx_path) else $error("rx path reset mismatch");

  property p_tx_csl;
    ctrl_ff.tx_control_sublayer_reset == (cfg_ff[`MCR_B_TXCSL] | cfg_ff[`MCR_B_WIDE]);
  endproperty
  a_tx_csl: assert property (p_tx_csl) else $error("tx control sub-layer reset mismatch");

  property p_tx_path;
    ctrl_ff.tx_path_reset == (cfg_ff[`MCR_B_TXPATH] | cfg_ff[`MCR_B_WIDE]);
  endproperty
  a_tx_path: assert property (p_tx_path) else $error("tx path reset mismatch");

  property p_byte_ignored;
    (wr_commit && !width_ok(wstrb_ff)) |=> $stable(cfg_ff);
  endproperty
  a_byte_ignored: assert property (p_byte_ignored) else $error("byte write changed the register");

  property p_set_alias;
    (wr_commit && waddr_ff == `MCR_OFF_SET && wstrb_ff == 4'hf)
      |=> ((cfg_ff & $past(wdata_ff[15:0]) & `MCR_CFG_IMPL) == ($past(wdata_ff[15:0]) & `MCR_CFG_IMPL));
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias did not set bits");

  property p_reset_value;
    $past(!aresetn) |-> cfg_ff == `MCR_CFG_RST && ctrl_ff.receive_on && ctrl_ff.pause_obey;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("wrong value after reset");

  property p_read_zero;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && (s_axi_rdata[15:0] & ~`MCR_CFG_IMPL) == 16'h0000;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unimplemented bits read nonzero");

  property p_hold_level;
    (cfg_ff[`MCR_B_WIDE] && !wr_apply) |=> cfg_ff[`MCR_B_WIDE];
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("reset bit cleared itself");

endmodule : mcr_top
`default_nettype wire

// ===== tb/test_mac_config_reset_control.sv
// self-checking bench for the mac configuration register block
`timescale 1ns/1ps
`default_nettype none
`include "mcr_cfg.svh"

module test_mac_config_reset_control;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
    logic [1:0]  resp;
    logic [15:0] reg_val;
  } mcr_row_s;

  logic               aclk          = 1'b0;
  logic               aresetn       = 1'b0;
  logic [7:0]         s_axi_awaddr  = 8'h00;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_awready;
  logic [31:0]        s_axi_wdata   = 32'h0000_0000;
  logic [3:0]         s_axi_wstrb   = 4'h0;
  logic               s_axi_wvalid  = 1'b0;
  logic               s_axi_wready;
  logic [1:0]         s_axi_bresp;
  logic               s_axi_bvalid;
  logic               s_axi_bready  = 1'b0;
  logic [7:0]         s_axi_araddr  = 8'h00;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_arready;
  logic [31:0]        s_axi_rdata;
  logic [1:0]         s_axi_rresp;
  logic               s_axi_rvalid;
  logic               s_axi_rready  = 1'b0;
  mcr_pkg::mcr_ctrl_s ctrl_o;
  logic [15:0]        backoff_random_value;
  logic [1:0]         resp;
  logic [31:0]        rdata;
  logic [15:0]        v;
  int                 mismatches    = 0;
  int                 n_tests       = 0;
  mcr_row_s           rows [10];

  mcr_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ctrl_o(ctrl_o), .backoff_random_value(backoff_random_value)
  );

  initial begin
    forever #10 aclk = ~aclk;
  end

  // sub-resets follow their own bit or the whole-mac hold
  function automatic logic [31:0] exp_ctrl(input logic [15:0] r);
    exp_ctrl = {21'h0, r[15], r[14] | r[15], r[11] | r[15], r[10] | r[15], r[9] | r[15],
                r[8] | r[15], r[4], r[3], r[2], r[1], r[0]};
  endfunction : exp_ctrl

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    lfsr_next = {1'b0, x[15:1]} ^ (x[0] ? `MCR_LFSR_TAPS : 16'h0000);
  endfunction : lfsr_next

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run;
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // each channel released at its own handshake edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic done;
    int   n;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done && n < 64) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      mismatches++;
      $display("[FAIL] write response expected %h seen %h", 1'b1, 1'b0);
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    int   n;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done && n < 64) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      mismatches++;
      $display("[FAIL] read response expected %h seen %h", 1'b1, 1'b0);
    end
  endtask : axi_read

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    complete_run();
  end

  initial begin
    rows = '{
      '{`MCR_OFF_CFG, 32'hffff_ffff, 4'hf, `MCR_RESP_OKAY,   16'hcf1f},
      '{`MCR_OFF_CLR, 32'h0000_cf1f, 4'h3, `MCR_RESP_OKAY,   16'h0000},
      '{`MCR_OFF_SET, 32'h0000_0810, 4'hf, `MCR_RESP_OKAY,   16'h0810},
      '{`MCR_OFF_INV, 32'h0000_4411, 4'h3, `MCR_RESP_OKAY,   16'h4c01},
      '{`MCR_OFF_CFG, 32'h0000_ffff, 4'h1, `MCR_RESP_OKAY,   16'h4c01},
      '{`MCR_OFF_CFG, 32'h0000_ffff, 4'hc, `MCR_RESP_OKAY,   16'h4c01},
      '{`MCR_OFF_SET, 32'h0000_ffff, 4'h2, `MCR_RESP_OKAY,   16'h4c01},
      '{8'h10,        32'h0000_ffff, 4'hf, `MCR_RESP_SLVERR, 16'h4c01},
      '{`MCR_OFF_CFG, 32'h0000_020a, 4'h3, `MCR_RESP_OKAY,   16'h020a},
      '{`MCR_OFF_CFG, 32'h0000_0000, 4'hf, `MCR_RESP_OKAY,   16'h0000}
    };
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      axi_write(rows[i].addr, rows[i].data, rows[i].strb, resp);
      check("bresp", {30'h0, rows[i].resp}, {30'h0, resp});
      axi_read(`MCR_OFF_CFG, rdata, resp);
      check("rdata", {16'h0000, rows[i].reg_val}, rdata);
      check("rresp", {30'h0, `MCR_RESP_OKAY}, {30'h0, resp});
      check("ctrl_o", exp_ctrl(rows[i].reg_val), {21'h0, ctrl_o});
    end
    // alias and unmapped reads
    axi_write(`MCR_OFF_CFG, 32'h0000_4f1f, 4'hf, resp);
    axi_read(`MCR_OFF_INV, rdata, resp);
    check("alias rdata", 32'h0000_4f1f, rdata);
    axi_read(8'h14, rdata, resp);
    check("unmapped rresp", {30'h0, `MCR_RESP_SLVERR}, {30'h0, resp});
    check("unmapped rdata", 32'h0000_0000, rdata);
    repeat (20) @(posedge aclk);
    check("held ctrl_o", exp_ctrl(16'h4f1f), {21'h0, ctrl_o});
    check("backoff seed", {16'h0000, `MCR_LFSR_SEED}, {16'h0000, backoff_random_value});
    axi_write(`MCR_OFF_CLR, 32'h0000_4000, 4'hf, resp);
    repeat (3) @(posedge aclk);
    // generator runs freely once released
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      v = backoff_random_value;
      @(posedge aclk);
      check("backoff step", {16'h0000, lfsr_next(v)}, {16'h0000, backoff_random_value});
    end
    // reset in mid-run restores the power-on pattern
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`MCR_OFF_CFG, rdata, resp);
    check("reset rdata", {16'h0000, `MCR_CFG_RST}, rdata);
    check("reset ctrl_o", exp_ctrl(`MCR_CFG_RST), {21'h0, ctrl_o});
    complete_run();
  end
endmodule : test_mac_config_reset_control
`default_nettype wire
